/* File: rtl/instr_decode_defines.vh */
// Opcode field positions, group codes, pointer modes and cycle counts for the instruction decoder.
// Assumes inclusion by the decoder module only.
`ifndef INSTR_DECODE_DEFINES_VH
`define INSTR_DECODE_DEFINES_VH

`define IW_WIDTH        14
`define IW_GROUP_HI     13
`define IW_GROUP_LO     12
`define IW_OP_HI        11
`define IW_OP_LO        8
`define IW_DEST_BIT     7
`define IW_FILE_HI      6
`define IW_FILE_LO      0
`define IW_BIT_HI       9
`define IW_BIT_LO       7
`define IW_BITOP_HI     11
`define IW_BITOP_LO     10
`define IW_PTR_BIT      2
`define IW_MODE_HI      1
`define IW_MODE_LO      0

`define GROUP_BYTE      2'h0
`define GROUP_BIT       2'h1
`define GROUP_JUMP      2'h2
`define GROUP_LIT       2'h3

`define CLASS_BYTE      2'h0
`define CLASS_BIT       2'h1
`define CLASS_LITCTL    2'h2

`define MODE_PRE_INC    2'h0
`define MODE_PRE_DEC    2'h1
`define MODE_POST_INC   2'h2
`define MODE_POST_DEC   2'h3

`define OP_RETURN_LIT   4'h4

`define INDIRECT_ADDR0  7'h00
`define INDIRECT_ADDR1  7'h01

`define OSC_PER_CYCLE   3'h4
`define PHASE_LAST      2'h3

`endif

/* File: rtl/instruction_cycle_decode.v */
// Instruction decode and cycle timing for an 8-bit core with 14-bit instruction words.
// Assumes the word is presented on instr_in by the fetch logic, held stable over an
// instruction cycle, and sampled at the last oscillator phase of that cycle.
`timescale 1ns/1ps
`default_nettype none
`include "instr_decode_defines.vh"

module instruction_cycle_decode #(
    parameter IW = 14
) (
    input  wire          clk_in,             // Oscillator clock, 40 MHz.
    input  wire          reset_n_in,         // Asynchronous reset, active low.
    input  wire [IW-1:0] instr_in,           // Fetched instruction word.
    input  wire          skip_true_in,       // Skip condition of the current instruction holds.
    input  wire          ptr0_msb_in,        // Pointer 0 addresses program memory.
    input  wire          ptr1_msb_in,        // Pointer 1 addresses program memory.
    output reg  [1:0]    phase_out,          // Oscillator phase within the instruction cycle.
    output reg           cycle_end_out,      // Pulse on the last phase of every instruction cycle.
    output reg           fetch_out,          // Pulse: a new instruction word is taken.
    output reg           flush_out,          // Level: current cycle executes as no_operation.
    output reg  [1:0]    class_out,          // Instruction class of the word taken.
    output reg  [6:0]    file_addr_out,      // File address operand.
    output reg  [2:0]    bit_sel_out,        // Bit number operand.
    output reg  [10:0]   literal_out,        // Literal operand, low 11 bits of the word as taken.
    output reg           file_read_out,      // File register read is performed.
    output reg           file_write_out,     // Result stored to the file register.
    output reg           acc_write_out,      // Result stored to the accumulator.
    output reg           ptr_sel_out,        // Selected indirect pointer pair.
    output reg  [1:0]    ptr_mode_out,       // Pointer update mode of indirect moves.
    output reg           ptr_move_out,       // Instruction is an indirect move.
    output reg  [2:0]    flag_we_out,        // Write enables for carry, digit carry, zero.
    output reg  [1:0]    cycles_out          // Instruction cycles this instruction takes.
);

    reg  [1:0] phase_r;
    reg  [1:0] extra_r;

    // File operations that live in the upper opcode group (shifts, carry add, borrow subtract).
    function is_file_lit;
        input [1:0] g;
        input [3:0] op;
        begin
            is_file_lit = (g == `GROUP_LIT) &&
                          ((op == 4'h5) || (op == 4'h6) || (op == 4'h7) || (op == 4'hb) || (op == 4'hd));
        end
    endfunction

    // Literal and control words that leave their result in the accumulator.
    function writes_acc_lit;
        input [3:0] op;
        begin
            case (op)
                4'h0, `OP_RETURN_LIT, 4'h8, 4'h9, 4'ha, 4'hc, 4'he: writes_acc_lit = 1'b1;
                default: writes_acc_lit = 1'b0;
            endcase
        end
    endfunction

    // Cycle count for a word: base one, two for flow changes, plus one indirect penalty.
    function [1:0] cycles_of;
        input [IW-1:0] w;
        input          skip;
        input          p0;
        input          p1;
        reg            flow;
        reg            ind;
        begin
            flow = 1'b0;
            ind  = 1'b0;
            case (w[`IW_GROUP_HI:`IW_GROUP_LO])
                `GROUP_JUMP: flow = 1'b1;
                `GROUP_LIT: flow = (w[11:9] == 3'h1) ||
                                   (w[11:8] == `OP_RETURN_LIT);
                `GROUP_BIT: flow = w[11] & skip;
                default: begin
                    flow = ((w[11:8] == 4'hb) || (w[11:8] == 4'hf)) & skip;
                    if (w[11:4] == 8'h00) begin
                        // Returns, indirect call and branch by accumulator.
                        flow = (w[3:0] == 4'h8) || (w[3:0] == 4'h9) ||
                               (w[3:0] == 4'ha) || (w[3:0] == 4'hb);
                    end
                end
            endcase
            if ((w[`IW_GROUP_HI] == 1'b0 && (w[11:4] != 8'h00 || w[3] == 1'b0)) ||
                is_file_lit(w[`IW_GROUP_HI:`IW_GROUP_LO], w[11:8])) begin
                if (w[`IW_FILE_HI:`IW_FILE_LO] == `INDIRECT_ADDR0) ind = p0;
                if (w[`IW_FILE_HI:`IW_FILE_LO] == `INDIRECT_ADDR1) ind = p1;
            end
            cycles_of = 2'h1 + {1'b0, flow} + {1'b0, ind};
        end
    endfunction

    wire [1:0] grp      = instr_in[`IW_GROUP_HI:`IW_GROUP_LO];
    wire       at_end   = (phase_r == `PHASE_LAST);
    wire       take     = at_end && (extra_r == 2'h0);
    wire [1:0] cyc_nxt  = cycles_of(instr_in, skip_true_in, ptr0_msb_in, ptr1_msb_in);
    wire       is_move  = (grp == `GROUP_BYTE) && (instr_in[11:4] == 8'h01);
    // The store-from-accumulator word has opcode nibble zero but still writes its file operand.
    wire       byte_wr  = (grp == `GROUP_BYTE) &&
                          ((instr_in[11:8] != 4'h0) || instr_in[`IW_DEST_BIT]);
    wire       lit_file = is_file_lit(grp, instr_in[11:8]);

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_r        <= 2'h0;
            extra_r        <= 2'h0;
            phase_out      <= 2'h0;
            cycle_end_out  <= 1'b0;
            fetch_out      <= 1'b0;
            flush_out      <= 1'b0;
            class_out      <= `CLASS_BYTE;
            file_addr_out  <= 7'h00;
            bit_sel_out    <= 3'h0;
            literal_out    <= 11'h000;
            file_read_out  <= 1'b0;
            file_write_out <= 1'b0;
            acc_write_out  <= 1'b0;
            ptr_sel_out    <= 1'b0;
            ptr_mode_out   <= `MODE_PRE_INC;
            ptr_move_out   <= 1'b0;
            flag_we_out    <= 3'h0;
            cycles_out     <= 2'h1;
        end else begin
            phase_r       <= phase_r + 2'h1;
            phase_out     <= phase_r + 2'h1;
            cycle_end_out <= (phase_r == 2'h2);
            fetch_out     <= take;
            if (at_end && extra_r != 2'h0) begin
                extra_r        <= extra_r - 2'h1;
                flush_out      <= 1'b1;
                file_read_out  <= 1'b0;
                file_write_out <= 1'b0;
                acc_write_out  <= 1'b0;
                flag_we_out    <= 3'h0;
                ptr_move_out   <= 1'b0;
            end else if (take) begin
                extra_r        <= cyc_nxt - 2'h1;
                cycles_out     <= cyc_nxt;
                flush_out      <= 1'b0;
                file_addr_out  <= instr_in[`IW_FILE_HI:`IW_FILE_LO];
                bit_sel_out    <= instr_in[`IW_BIT_HI:`IW_BIT_LO];
                literal_out    <= instr_in[10:0];
                ptr_sel_out    <= instr_in[`IW_PTR_BIT];
                ptr_mode_out   <= instr_in[`IW_MODE_HI:`IW_MODE_LO];
                ptr_move_out   <= is_move;
                // Register index bits above the field and don't-care bits never gate decode.
                case (grp)
                    `GROUP_BYTE: begin
                        class_out      <= `CLASS_BYTE;
                        file_read_out  <= byte_wr;
                        file_write_out <= byte_wr && instr_in[`IW_DEST_BIT];
                        acc_write_out  <= byte_wr && !instr_in[`IW_DEST_BIT];
                        case (instr_in[11:8])
                            4'h2, 4'h7: flag_we_out <= 3'h7;
                            4'hd, 4'hc: flag_we_out <= 3'h4;
                            4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'he:
                                flag_we_out <= 3'h1;
                            default: flag_we_out <= 3'h0;
                        endcase
                    end
                    `GROUP_BIT: begin
                        class_out      <= `CLASS_BIT;
                        file_read_out  <= 1'b1;
                        file_write_out <= !instr_in[11];
                        acc_write_out  <= 1'b0;
                        flag_we_out    <= 3'h0;
                    end
                    `GROUP_JUMP: begin
                        class_out      <= `CLASS_LITCTL;
                        file_read_out  <= 1'b0;
                        file_write_out <= 1'b0;
                        acc_write_out  <= 1'b0;
                        flag_we_out    <= 3'h0;
                    end
                    default: begin
                        class_out      <= lit_file ? `CLASS_BYTE : `CLASS_LITCTL;
                        file_read_out  <= lit_file;
                        file_write_out <= lit_file && instr_in[`IW_DEST_BIT];
                        acc_write_out  <= lit_file ? !instr_in[`IW_DEST_BIT]
                                                   : writes_acc_lit(instr_in[11:8]);
                        case (instr_in[11:8])
                            4'he, 4'hf, 4'hc, 4'hd, 4'hb: flag_we_out <= 3'h7;
                            4'h5, 4'h6, 4'h7: flag_we_out <= 3'h5;
                            4'h8, 4'h9, 4'ha: flag_we_out <= 3'h1;
                            default: flag_we_out <= 3'h0;
                        endcase
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: verification/icd_properties.sv */
// Port-level checker for the instruction decoder, bound into every instance.
// Assumes one clock domain and the registered one-clock answer of the decoder.
`timescale 1ns/1ps
`default_nettype none
module decode_checker (
    input wire logic        clk_in, reset_n_in,             // Clock and reset.
    input wire logic [13:0] instr_in,                       // Offered word.
    input wire logic [1:0]  phase_out, class_out, ptr_mode_out, cycles_out, // Phase and fields.
    input wire logic        cycle_end_out, fetch_out, flush_out, ptr_sel_out, ptr_move_out, // Strobes.
    input wire logic        file_read_out, file_write_out, acc_write_out, // Enables.
    input wire logic [6:0]  file_addr_out,                  // File address.
    input wire logic [2:0]  bit_sel_out, flag_we_out,       // Bit number and flag enables.
    input wire logic [10:0] literal_out                     // Literal.
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Holds the word as it stood at the take edge, so it lines up with fetch_out.
    logic [13:0] taken_r;
    always_ff @(posedge clk_in) taken_r <= instr_in;
    AST_PHASE_STEP: assert property ($past(reset_n_in) |-> phase_out - $past(phase_out) == 2'h1)
        else $error("phase does not advance by one");
    AST_CYCLE_END: assert property (cycle_end_out == (phase_out == 2'h3))
        else $error("cycle end off phase three");
    AST_FETCH_PHASE: assert property (fetch_out |-> phase_out == 2'h0 && !flush_out)
        else $error("fetch off a cycle boundary");
    AST_ONE_CYCLE: assert property (fetch_out && cycles_out == 2'h1 |=> !fetch_out [*3] ##1 fetch_out)
        else $error("single cycle word spacing wrong");
    AST_TWO_CYCLE: assert property (fetch_out && cycles_out == 2'h2 |=> !flush_out [*3] ##1 flush_out [*4] ##1 fetch_out)
        else $error("two cycle word timing wrong");
    AST_THREE_CYCLE: assert property (fetch_out && cycles_out == 2'h3 |=> !flush_out [*3] ##1 flush_out [*8] ##1 fetch_out)
        else $error("three cycle word timing wrong");
    AST_FLUSH_QUIET: assert property (flush_out |-> !(file_read_out | file_write_out | acc_write_out) && flag_we_out == 3'h0)
        else $error("enables active in flush cycle");
    AST_DEST: assert property (fetch_out && class_out == 2'h0 && !ptr_move_out && (file_write_out || acc_write_out)
        |-> file_write_out == taken_r[7] && acc_write_out == !taken_r[7])
        else $error("destination select wrong");
    AST_RMW_READ: assert property (fetch_out && file_write_out && !ptr_move_out |-> file_read_out)
        else $error("file write without read");
    AST_BIT_SEL: assert property (fetch_out && class_out == 2'h1 |-> bit_sel_out == taken_r[9:7] && file_addr_out == taken_r[6:0])
        else $error("bit or file field wrong");
    AST_LITERAL: assert property (fetch_out && taken_r[13:12] == 2'h2 |-> literal_out == taken_r[10:0] && cycles_out == 2'h2)
        else $error("literal field or cycles wrong");
    AST_PTR: assert property (fetch_out && ptr_move_out |-> ptr_sel_out == taken_r[2] && ptr_mode_out == taken_r[1:0])
        else $error("pointer fields wrong");
endmodule
bind instruction_cycle_decode decode_checker decode_checker_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .instr_in(instr_in), .phase_out(phase_out), .class_out(class_out), .ptr_mode_out(ptr_mode_out),
    .cycles_out(cycles_out), .cycle_end_out(cycle_end_out), .fetch_out(fetch_out), .flush_out(flush_out),
    .ptr_sel_out(ptr_sel_out), .ptr_move_out(ptr_move_out), .file_read_out(file_read_out),
    .file_write_out(file_write_out), .acc_write_out(acc_write_out), .file_addr_out(file_addr_out),
    .bit_sel_out(bit_sel_out), .flag_we_out(flag_we_out), .literal_out(literal_out));
`default_nettype wire

/* File: verification/instruction_cycle_decode_tb.sv */
// Self-checking bench: words are offered back to back and decode and cycle counts are judged.
// Assumes the decoder and its bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_decode_tb;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, skip_true_in = 1'b0;
    logic [13:0] instr_in = 14'h0000;
    logic [1:0]  ptr_msb = 2'h0;
    wire  [1:0]  class_v, cycles;
    wire  [2:0]  flg;
    wire         fetch, flush, rd, wr, acc;
    int          fails = 0, num_checks = 0;
    always #12.5 clk_in = ~clk_in;
    instruction_cycle_decode instruction_cycle_decode_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .instr_in(instr_in), .skip_true_in(skip_true_in), .ptr0_msb_in(ptr_msb[0]), .ptr1_msb_in(ptr_msb[1]),
        .phase_out(), .cycle_end_out(), .fetch_out(fetch), .flush_out(flush), .class_out(class_v),
        .file_addr_out(), .bit_sel_out(), .literal_out(), .file_read_out(rd), .file_write_out(wr),
        .acc_write_out(acc), .ptr_sel_out(), .ptr_mode_out(), .ptr_move_out(), .flag_we_out(flg),
        .cycles_out(cycles));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Offers one word, then follows it up to two clocks before the next take edge.
    task automatic issue(input logic [13:0] w, input logic s, input logic [1:0] p, input logic [1:0] n,
                         input logic [7:0] exp, input logic [7:0] msk);
        int k;
        @(posedge clk_in);
        instr_in <= w;
        skip_true_in <= s;
        ptr_msb <= p;
        for (k = 0; k < 20 && fetch !== 1'b1; k++) begin
            @(posedge clk_in);
            #1;
        end
        chk("fetch", 16'h0001, 16'(fetch));
        chk("cycles", 16'(n), 16'(cycles));
        chk("decode", 16'(exp & msk), 16'({class_v, flg, rd, wr, acc} & msk));
        for (k = 1; k <= 4 * n - 2; k++) begin
            @(posedge clk_in);
            #1;
            chk("flush", 16'(k >= 4), 16'(flush));
            chk("fetch", 16'h0000, 16'(fetch));
        end
    endtask
    task automatic byte_ops;
        issue(14'h0705, 1'b0, 2'h0, 2'd1, 8'h3d, 8'hff);
        issue(14'h0785, 1'b0, 2'h0, 2'd1, 8'h3e, 8'hff);
        issue(14'h00a3, 1'b0, 2'h0, 2'd1, 8'h06, 8'hff);
        issue(14'h0103, 1'b0, 2'h0, 2'd1, 8'h09, 8'hfb);
        issue(14'h0100, 1'b0, 2'h0, 2'd1, 8'h09, 8'hfb);
        issue(14'h0780, 1'b0, 2'h1, 2'd2, 8'h3e, 8'hff);
        issue(14'h0780, 1'b0, 2'h2, 2'd1, 8'h3e, 8'hff);
        issue(14'h0b81, 1'b1, 2'h2, 2'd3, 8'h06, 8'hff);
        issue(14'h0bff, 1'b1, 2'h0, 2'd2, 8'h06, 8'hff);
        issue(14'h0bff, 1'b0, 2'h0, 2'd1, 8'h06, 8'hff);
        issue(14'h0fff, 1'b1, 2'h0, 2'd2, 8'h06, 8'hff);
    endtask
    task automatic bit_ops;
        issue(14'h1290, 1'b0, 2'h0, 2'd1, 8'h46, 8'hff);
        issue(14'h1fff, 1'b1, 2'h0, 2'd2, 8'h44, 8'hff);
        issue(14'h1fff, 1'b0, 2'h0, 2'd1, 8'h44, 8'hff);
        issue(14'h1bff, 1'b1, 2'h0, 2'd2, 8'h44, 8'hff);
    endtask
    task automatic flow_ops;
        int i;
        issue(14'h2fff, 1'b0, 2'h0, 2'd2, 8'h80, 8'hff);
        issue(14'h2555, 1'b0, 2'h0, 2'd2, 8'h80, 8'hff);
        issue(14'h3355, 1'b0, 2'h0, 2'd2, 8'h80, 8'hfa);
        for (i = 8; i < 12; i++)
            issue(14'(i), 1'b0, 2'h0, 2'd2, 8'h00, 8'h3a);
        for (i = 0; i < 8; i++)
            issue(14'h0010 + 14'(i), 1'b0, 2'h0, 2'd1, 8'h00, 8'hc0);
    endtask
    task automatic lit_ops;
        issue(14'h3455, 1'b0, 2'h0, 2'd2, 8'h81, 8'hff);
        issue(14'h3585, 1'b0, 2'h0, 2'd1, 8'h2e, 8'hff);
        issue(14'h3705, 1'b0, 2'h0, 2'd1, 8'h2d, 8'hff);
        issue(14'h3e12, 1'b0, 2'h0, 2'd1, 8'hb9, 8'hff);
        issue(14'h3180, 1'b0, 2'h0, 2'd1, 8'h80, 8'hff);
        issue(14'h3580, 1'b0, 2'h1, 2'd2, 8'h2e, 8'hff);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        byte_ops();
        bit_ops();
        flow_ops();
        lit_ops();
        final_report();
    end
    initial begin
        #40000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
